// >>> core/wdc_top.sv
/*
  Watchdog with window mode, periodic timer, self-clock fallback with
  quality checker, and wait-mode clock gating sequence.
  Assumes osc_edge and vco_tick are one-cycle pulses synchronous to ref_clk,
  and that the core turns reset requests into a system reset.
*/
// Functional notes
// - Watchdog idle after reset until software gives it a nonzero rate.
// - Three-bit rate picks seven watchdog periods; zero rate stops it.
// - Key 0x0055 then 0x00aa restarts period; expiry requests reset.
// - While rate is nonzero, any other value written to service register requests reset at once.
// - Window mode: service only in last quarter, earlier write resets.
// - Watchdog pseudo-stop enable keeps watchdog counting in pseudo-stop.
// - Periodic interrupt raised at selected rate when its enable is set.
// - Periodic expiry sets flag and next interval starts immediately.
// - Writing periodic rate register restarts the interval.
// - Periodic pseudo-stop enable keeps it running; zero rate stops it.
// - Monitor plus self-clock enable on failure runs from minimum VCO.
// - Entering self-clock mode clears PLL clock select.
// - Quality check success leaves self-clock mode automatically.
// - Clock monitor reset forces self-clock enable to one.
// - Wait gating bits act on PLL, core, system, timers; system bit also stops core.
// - Wait entry: drop PLL select and PLL, then core, then system clocks.
// - External reset asynchronously restores all configuration to defaults.
// - Failure without self-clock enable gives clock monitor reset.
// - Failure with self-clock enable sets flag, enters mode, wakes if enabled.
// - Other interrupts wake at once; PLL select stays cleared.
// - Quality checking continues in wait with PLL and regulator on.
// - Oscillator good at 4096 edges within 50000 VCO ticks.
`timescale 1ns/1ps
module wdc_top #(
  parameter int WD_BASE     = wdc_pkg::WD_BASE_DEF,
  parameter int PER_BASE    = wdc_pkg::PER_BASE_DEF,
  parameter int QC_WINDOW   = wdc_pkg::QC_WINDOW,
  parameter int QC_OK_EDGES = wdc_pkg::QC_OK_EDGES
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // Register port
  input  wire logic [7:0]        addr,
  input  wire logic [15:0]       wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic [15:0]            rdata,
  // Clock sources and core requests
  input  wire logic              osc_edge,
  input  wire logic              vco_tick,
  input  wire logic              clock_fail,
  input  wire logic              wait_req,
  input  wire logic              pseudo_stop,
  input  wire logic              wake_irq,
  // Reset and interrupt requests
  output logic                   wdog_reset,
  output logic                   cm_reset,
  output logic                   periodic_irq,
  output logic                   self_clock_irq,
  // Clock control
  output wdc_pkg::wdc_gate_t     gate,
  output logic                   pll_clock_select,
  output logic                   self_clock_mode,
  output logic                   wait_active
);
  if (WD_BASE < 1 || WD_BASE > 9) $error("WD_BASE out of range");
  if (PER_BASE < 1 || PER_BASE > 8) $error("PER_BASE out of range");
  if (QC_WINDOW < 2 || QC_WINDOW > 65535) $error("QC_WINDOW out of range");
  if (QC_OK_EDGES < 2 || QC_OK_EDGES > 65535) $error("QC_OK_EDGES out of range");

  logic [2:0]  wrate_r, wrate_nxt;
  logic        wwin_r, wwin_nxt;
  logic        warm_r, warm_nxt;
  logic [23:0] wcnt_r, wcnt_nxt;
  logic [2:0]  prate_r, prate_nxt;
  logic [15:0] pcnt_r, pcnt_nxt;
  logic [8:0]  csel_r, csel_nxt;
  logic [3:0]  mon_r, mon_nxt;
  logic        pflag_r, pflag_nxt;
  logic        sflag_r, sflag_nxt;
  logic        scm_r, scm_nxt;
  logic        qc_r, qc_nxt;
  logic [15:0] qwin_r, qwin_nxt;
  logic [15:0] qedge_r, qedge_nxt;
  wdc_pkg::wdc_state_t st_r, st_nxt;
  wdc_pkg::wdc_gate_t  gate_nxt;
  logic        wrst_nxt, cmrst_nxt, pirq_nxt, sirq_nxt;
  logic [15:0] rdata_nxt;
  logic        wtick, ptick, svc_wr, fail, wake, qc_ok;
  logic [23:0] wper;
  logic [15:0] pper;
  logic [4:0]  wsh, psh;

  assign wsh  = 5'(WD_BASE) + 5'({wrate_r, 1'b0});
  assign psh  = 5'(PER_BASE) + 5'(prate_r);
  assign wper = 24'h1 << wsh;
  assign pper = 16'h1 << psh;
  assign svc_wr = wr_en && addr == wdc_pkg::OFS_WDOG_SVC;
  assign fail = clock_fail && mon_r[wdc_pkg::MC_CME];
  assign wake = wake_irq || periodic_irq || self_clock_irq;
  assign wtick = osc_edge && wrate_r != 3'h0
                 && !(wait_active && csel_r[wdc_pkg::CS_WDOG_WAIT])
                 && !(pseudo_stop && !csel_r[wdc_pkg::CS_WDOG_PSE]);
  assign ptick = osc_edge && prate_r != 3'h0
                 && !(wait_active && csel_r[wdc_pkg::CS_PER_WAIT])
                 && !(pseudo_stop && !csel_r[wdc_pkg::CS_PER_PSE]);
  assign qc_ok = qc_r && osc_edge && qedge_r == 16'(QC_OK_EDGES - 1);

  always_comb begin
    wrate_nxt = wrate_r;
    wwin_nxt  = wwin_r;
    warm_nxt  = warm_r;
    wcnt_nxt  = wcnt_r;
    prate_nxt = prate_r;
    pcnt_nxt  = pcnt_r;
    csel_nxt  = csel_r;
    mon_nxt   = mon_r;
    pflag_nxt = pflag_r;
    sflag_nxt = sflag_r;
    scm_nxt   = scm_r;
    qc_nxt    = qc_r;
    qwin_nxt  = qwin_r;
    qedge_nxt = qedge_r;
    st_nxt    = st_r;
    gate_nxt  = gate;
    wrst_nxt  = 1'b0;
    cmrst_nxt = 1'b0;
    rdata_nxt = 16'h0000;
    if (wtick) begin
      if (wcnt_r >= wper - 24'h1) begin
        wrst_nxt = 1'b1;
        wcnt_nxt = 24'h0;
      end else begin
        wcnt_nxt = wcnt_r + 24'h1;
      end
    end
    if (svc_wr && wrate_r != 3'h0) begin
      if (wdata != wdc_pkg::SVC_KEY1 && wdata != wdc_pkg::SVC_KEY2) begin
        wrst_nxt = 1'b1;
      end else if (wwin_r && wcnt_r < wper - (wper >> 2)) begin
        wrst_nxt = 1'b1;
      end else if (wdata == wdc_pkg::SVC_KEY1) begin
        warm_nxt = 1'b1;
      end else if (warm_r) begin
        warm_nxt = 1'b0;
        wcnt_nxt = 24'h0;
      end
    end
    if (ptick) begin
      if (pcnt_r >= pper - 16'h1) begin
        pcnt_nxt = 16'h0;
      end else begin
        pcnt_nxt = pcnt_r + 16'h1;
      end
    end
    if (wr_en) begin
      case (addr)
        wdc_pkg::OFS_WDOG_CTL: begin
          wrate_nxt = wdata[2:0];
          wwin_nxt  = wdata[wdc_pkg::WC_WIN];
          wcnt_nxt  = 24'h0;
          warm_nxt  = 1'b0;
        end
        wdc_pkg::OFS_PER_RATE: begin
          prate_nxt = wdata[2:0];
          pcnt_nxt  = 16'h0;
        end
        wdc_pkg::OFS_CLK_SEL: csel_nxt = wdata[8:0];
        wdc_pkg::OFS_MON_CTL: mon_nxt = wdata[3:0];
        wdc_pkg::OFS_FLAGS: begin
          pflag_nxt = pflag_r && !wdata[wdc_pkg::FL_PER];
          sflag_nxt = sflag_r && !wdata[wdc_pkg::FL_SCMF];
        end
        default: ;
      endcase
    end
    if (ptick && pcnt_r >= pper - 16'h1) begin
      pflag_nxt = 1'b1;
    end
    if (qc_r) begin
      if (osc_edge) begin
        qedge_nxt = qedge_r + 16'h1;
      end
      if (vco_tick) begin
        if (qwin_r == 16'(QC_WINDOW - 1)) begin
          qwin_nxt  = 16'h0;
          qedge_nxt = 16'h0;
        end else begin
          qwin_nxt = qwin_r + 16'h1;
        end
      end
      if (qc_ok) begin
        qc_nxt  = 1'b0;
        scm_nxt = 1'b0;
      end
    end
    if (fail) begin
      if (mon_r[wdc_pkg::MC_SELF_CLOCK_ENABLE]) begin
        scm_nxt   = 1'b1;
        sflag_nxt = 1'b1;
        csel_nxt[wdc_pkg::CS_PLL_SEL] = 1'b0;
        qc_nxt    = 1'b1;
        qwin_nxt  = 16'h0;
        qedge_nxt = 16'h0;
      end else begin
        cmrst_nxt = 1'b1;
        mon_nxt[wdc_pkg::MC_SELF_CLOCK_ENABLE] = 1'b1;
      end
    end
    case (st_r)
      wdc_pkg::WDC_RUN: begin
        if (wait_req) begin
          st_nxt = wdc_pkg::WDC_W_PLL;
        end
      end
      wdc_pkg::WDC_W_PLL: begin
        if (csel_r[wdc_pkg::CS_PLL_WAIT]) begin
          csel_nxt[wdc_pkg::CS_PLL_SEL] = 1'b0;
          gate_nxt.pll_en = 1'b0;
        end
        st_nxt = wdc_pkg::WDC_W_CORE;
      end
      wdc_pkg::WDC_W_CORE: begin
        if (csel_r[wdc_pkg::CS_CORE_WAIT] || csel_r[wdc_pkg::CS_SYS_WAIT]) begin
          gate_nxt.core_en = 1'b0;
        end
        st_nxt = wdc_pkg::WDC_W_SYS;
      end
      wdc_pkg::WDC_W_SYS: begin
        gate_nxt.sys_en     = !csel_r[wdc_pkg::CS_SYS_WAIT];
        gate_nxt.osc_reduce = csel_r[wdc_pkg::CS_OSC_RED];
        st_nxt = wdc_pkg::WDC_WAIT;
      end
      wdc_pkg::WDC_WAIT: begin
        // wake resumes at once, select stays cleared
        if (wake) begin
          gate_nxt.pll_en     = 1'b1;
          gate_nxt.core_en    = 1'b1;
          gate_nxt.sys_en     = 1'b1;
          gate_nxt.osc_reduce = 1'b0;
          st_nxt = wdc_pkg::WDC_RUN;
        end
      end
      default: st_nxt = wdc_pkg::WDC_RUN;
    endcase
    // checker keeps PLL and regulator alive
    if (qc_nxt || scm_nxt) begin
      gate_nxt.pll_en = 1'b1;
    end
    gate_nxt.voltage_regulator_en = !pseudo_stop || qc_nxt || scm_nxt;
    pirq_nxt = pflag_nxt && mon_nxt[wdc_pkg::MC_PERIE];
    sirq_nxt = sflag_nxt && mon_nxt[wdc_pkg::MC_SELF_CLOCK_IRQ_ENABLE];
    if (rd_en) begin
      case (addr)
        wdc_pkg::OFS_WDOG_CTL: rdata_nxt = {9'h000, wwin_r, 3'h0, wrate_r};
        wdc_pkg::OFS_PER_RATE: rdata_nxt = {13'h0000, prate_r};
        wdc_pkg::OFS_CLK_SEL:  rdata_nxt = {7'h00, csel_r};
        wdc_pkg::OFS_MON_CTL:  rdata_nxt = {12'h000, mon_r};
        wdc_pkg::OFS_FLAGS:    rdata_nxt = {11'h000, wait_active, qc_r, scm_r, sflag_r, pflag_r};
        default:               rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrate_r          <= 3'h0;
      wwin_r           <= 1'b0;
      warm_r           <= 1'b0;
      wcnt_r           <= 24'h0;
      prate_r          <= 3'h0;
      pcnt_r           <= 16'h0;
      csel_r           <= wdc_pkg::CLK_SEL_RST;
      mon_r            <= wdc_pkg::MON_CTL_RST;
      pflag_r          <= 1'b0;
      sflag_r          <= 1'b0;
      scm_r            <= 1'b0;
      qc_r             <= 1'b0;
      qwin_r           <= 16'h0;
      qedge_r          <= 16'h0;
      st_r             <= wdc_pkg::WDC_RUN;
      gate             <= wdc_pkg::GATE_RST;
      wdog_reset       <= 1'b0;
      cm_reset         <= 1'b0;
      periodic_irq     <= 1'b0;
      self_clock_irq   <= 1'b0;
      rdata            <= 16'h0000;
      pll_clock_select <= 1'b0;
      self_clock_mode  <= 1'b0;
      wait_active      <= 1'b0;
    end else begin
      wrate_r          <= wrate_nxt;
      wwin_r           <= wwin_nxt;
      warm_r           <= warm_nxt;
      wcnt_r           <= wcnt_nxt;
      prate_r          <= prate_nxt;
      pcnt_r           <= pcnt_nxt;
      csel_r           <= csel_nxt;
      mon_r            <= mon_nxt;
      pflag_r          <= pflag_nxt;
      sflag_r          <= sflag_nxt;
      scm_r            <= scm_nxt;
      qc_r             <= qc_nxt;
      qwin_r           <= qwin_nxt;
      qedge_r          <= qedge_nxt;
      st_r             <= st_nxt;
      gate             <= gate_nxt;
      wdog_reset       <= wrst_nxt;
      cm_reset         <= cmrst_nxt;
      periodic_irq     <= pirq_nxt;
      self_clock_irq   <= sirq_nxt;
      rdata            <= rdata_nxt;
      pll_clock_select <= csel_nxt[wdc_pkg::CS_PLL_SEL];
      self_clock_mode  <= scm_nxt;
      wait_active      <= st_nxt == wdc_pkg::WDC_WAIT;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_wdog_idle;
    wrate_r == 3'h0 |=> !wdog_reset;
  endproperty
  a_wdog_idle: assert property (p_wdog_idle) else $error("watchdog reset while idle");
  property p_wdog_expire;
    wtick && wcnt_r >= wper - 24'h1 |=> wdog_reset ##1 !wdog_reset;
  endproperty
  a_wdog_expire: assert property (p_wdog_expire) else $error("no reset on expiry");
  property p_bad_key;
    svc_wr && wrate_r != 3'h0 && wdata != wdc_pkg::SVC_KEY1 && wdata != wdc_pkg::SVC_KEY2 |=> wdog_reset;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("bad key not reset");
  property p_early;
    svc_wr && wrate_r != 3'h0 && wwin_r && wcnt_r < wper - (wper >> 2) |=> wdog_reset;
  endproperty
  a_early: assert property (p_early) else $error("early service not reset");
  property p_per_idle;
    prate_r == 3'h0 && !(wr_en && addr == wdc_pkg::OFS_PER_RATE) |=> $stable(pcnt_r);
  endproperty
  a_per_idle: assert property (p_per_idle) else $error("periodic runs at zero rate");
  property p_restart;
    svc_wr && warm_r && wdata == wdc_pkg::SVC_KEY2 && !wwin_r && !wrst_nxt |=> wcnt_r == 24'h0 && !warm_r;
  endproperty
  a_restart: assert property (p_restart) else $error("key pair did not restart");
  property p_per_flag;
    ptick && pcnt_r >= pper - 16'h1 && !(wr_en && addr == wdc_pkg::OFS_PER_RATE) |=> pflag_r && pcnt_r == 16'h0;
  endproperty
  a_per_flag: assert property (p_per_flag) else $error("periodic flag not set");
  property p_rate_wr;
    wr_en && addr == wdc_pkg::OFS_PER_RATE |=> pcnt_r == 16'h0;
  endproperty
  a_rate_wr: assert property (p_rate_wr) else $error("rate write no restart");
  property p_scm_enter;
    fail && mon_r[wdc_pkg::MC_SELF_CLOCK_ENABLE] && !(wr_en && addr == wdc_pkg::OFS_CLK_SEL)
      |=> self_clock_mode && !pll_clock_select && sflag_r;
  endproperty
  a_scm_enter: assert property (p_scm_enter) else $error("self-clock entry wrong");
  property p_cm_reset;
    fail && !mon_r[wdc_pkg::MC_SELF_CLOCK_ENABLE] |=> cm_reset && mon_r[wdc_pkg::MC_SELF_CLOCK_ENABLE];
  endproperty
  a_cm_reset: assert property (p_cm_reset) else $error("monitor reset wrong");
  property p_wait_seq;
    st_r == wdc_pkg::WDC_RUN && wait_req
      |=> st_r == wdc_pkg::WDC_W_PLL ##1 st_r == wdc_pkg::WDC_W_CORE ##1 st_r == wdc_pkg::WDC_W_SYS ##1 wait_active;
  endproperty
  a_wait_seq: assert property (p_wait_seq) else $error("wait sequence broken");
  property p_qc_exit;
    qc_ok && !fail |=> !self_clock_mode && !qc_r;
  endproperty
  a_qc_exit: assert property (p_qc_exit) else $error("self-clock not left");
  property p_qc_pll;
    qc_r && !qc_ok |=> gate.pll_en;
  endproperty
  a_qc_pll: assert property (p_qc_pll) else $error("PLL off during check");
  c_wdog_reset: cover property (wtick ##[1:8] wdog_reset);
  c_per_irq:    cover property (ptick ##1 periodic_irq);
  c_scm_cycle:  cover property (self_clock_mode ##[1:1000] !self_clock_mode);
  c_wait_wake:  cover property (wait_active ##1 !wait_active);
endmodule // wdc_top

// >>> core/wdc_pkg.sv
/*
  Constants, states and carriers for the watchdog, periodic timer,
  self-clock and wait-gating block.
  Assumes a plain register port with 8-bit byte addresses and 16-bit data.
*/
package wdc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_WDOG_CTL  = 8'h00;
  localparam logic [7:0] OFS_WDOG_SVC  = 8'h04;
  localparam logic [7:0] OFS_PER_RATE  = 8'h08;
  localparam logic [7:0] OFS_CLK_SEL   = 8'h0c;
  localparam logic [7:0] OFS_MON_CTL   = 8'h10;
  localparam logic [7:0] OFS_FLAGS     = 8'h14;
  // watchdog_control_reg fields: rate in [2:0]
  localparam int WC_WIN = 6;
  // clock_select_reg fields
  localparam int CS_WDOG_WAIT = 0;
  localparam int CS_PER_WAIT  = 1;
  localparam int CS_CORE_WAIT = 2;
  localparam int CS_OSC_RED   = 3;
  localparam int CS_SYS_WAIT  = 4;
  localparam int CS_PER_PSE   = 5;
  localparam int CS_WDOG_PSE  = 6;
  localparam int CS_PLL_SEL   = 7;
  localparam int CS_PLL_WAIT  = 8;
  // Monitor control fields
  localparam int MC_CME   = 0;
  localparam int MC_SELF_CLOCK_ENABLE  = 1;
  localparam int MC_SELF_CLOCK_IRQ_ENABLE = 2;
  localparam int MC_PERIE = 3;
  // Flag register fields
  localparam int FL_PER  = 0;
  localparam int FL_SCMF = 1;
  localparam int FL_SCM  = 2;
  localparam int FL_QC   = 3;
  localparam int FL_WAIT = 4;
  // Reset values
  localparam logic [8:0] CLK_SEL_RST = 9'h000;
  localparam logic [3:0] MON_CTL_RST = 4'h3;
  // Service keys
  localparam logic [15:0] SVC_KEY1 = 16'h0055;
  localparam logic [15:0] SVC_KEY2 = 16'h00aa;
  // Timing defaults
  localparam int WD_BASE_DEF  = 4;
  localparam int PER_BASE_DEF = 3;
  localparam int QC_WINDOW    = 50000;
  localparam int QC_OK_EDGES  = 4096;

  typedef enum logic [4:0] {
    WDC_RUN    = 5'h01,
    WDC_W_PLL  = 5'h02,
    WDC_W_CORE = 5'h04,
    WDC_W_SYS  = 5'h08,
    WDC_WAIT   = 5'h10
  } wdc_state_t;

  typedef struct packed {
    logic pll_en;
    logic voltage_regulator_en;
    logic core_en;
    logic sys_en;
    logic osc_reduce;
  } wdc_gate_t;

  localparam wdc_gate_t GATE_RST = 5'h1e;
endpackage

// >>> sim/wdc_tb_top.sv
/*
  Self-checking bench for wdc_top: register tasks, pulse drivers, checks.
  Assumes short quality-check counts so clock recovery stays brief.
*/
`timescale 1ns/1ps
module wdc_tb_top;
  localparam int WD = 4;
  logic               ref_clk = 1'h0;
  logic               rst_n = 1'h0;
  logic [7:0]         addr = 8'h00;
  logic [15:0]        wdata = 16'h0000;
  logic               wr_en = 1'h0;
  logic               rd_en = 1'h0;
  logic [15:0]        rdata;
  logic               osc_edge = 1'h0;
  logic               vco_tick = 1'h0;
  logic               clock_fail = 1'h0;
  logic               wait_req = 1'h0;
  logic               pseudo_stop = 1'h0;
  logic               wake_irq = 1'h0;
  logic               wdog_reset, cm_reset, periodic_irq, self_clock_irq;
  wdc_pkg::wdc_gate_t gate;
  logic               pll_clock_select, self_clock_mode, wait_active;
  logic [15:0]        v;
  int                 fails = 0, n_compared = 0, n_wdr = 0, n_cmr = 0;
  int                 cyc_n = 0, t_pll = 0, t_core = 0, t_sys = 0;

  wdc_top #(.WD_BASE(WD), .PER_BASE(3), .QC_WINDOW(20), .QC_OK_EDGES(8)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .osc_edge(osc_edge), .vco_tick(vco_tick),
    .clock_fail(clock_fail), .wait_req(wait_req), .pseudo_stop(pseudo_stop),
    .wake_irq(wake_irq), .wdog_reset(wdog_reset), .cm_reset(cm_reset),
    .periodic_irq(periodic_irq), .self_clock_irq(self_clock_irq), .gate(gate),
    .pll_clock_select(pll_clock_select), .self_clock_mode(self_clock_mode),
    .wait_active(wait_active));

  always #20 ref_clk = ~ref_clk;

  // Reset pulses are one cycle, so count them at each edge
  always @(posedge ref_clk) begin
    if (wdog_reset === 1'h1) n_wdr++;
    if (cm_reset === 1'h1) n_cmr++;
  end

  // First cycle each clock gate drops, to see the shutdown order
  always @(negedge ref_clk) begin
    cyc_n++;
    if (gate.pll_en === 1'h0 && t_pll == 0) t_pll = cyc_n;
    if (gate.core_en === 1'h0 && t_core == 0) t_core = cyc_n;
    if (gate.sys_en === 1'h0 && t_sys == 0) t_sys = cyc_n;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'h1;
    @(posedge ref_clk);
    wr_en <= 1'h0;
  endtask
  task automatic rm(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'h1;
    @(posedge ref_clk);
    rd_en <= 1'h0;
    #1 chk(rdata & m, e);
  endtask
  task automatic osc(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      osc_edge <= 1'h1;
    end
    @(posedge ref_clk);
    osc_edge <= 1'h0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Level inputs raised for one cycle; 0 fail, 1 wait, 2 wake
  task automatic pls(input int s);
    @(posedge ref_clk);
    if (s == 0) clock_fail <= 1'h1; else if (s == 1) wait_req <= 1'h1; else wake_irq <= 1'h1;
    @(posedge ref_clk);
    clock_fail <= 1'h0;
    wait_req   <= 1'h0;
    wake_irq   <= 1'h0;
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Whole run needs a few thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    close_out();
  end

  initial begin
    int b;
    repeat (16) @(posedge ref_clk);
    chk({11'h0, gate}, 16'h001e);  // gate default
    rst_n <= 1'h1;
    rm(wdc_pkg::OFS_WDOG_CTL, 16'hffff, 16'h0000);  // watchdog off
    rm(wdc_pkg::OFS_PER_RATE, 16'hffff, 16'h0000);  // periodic off
    rm(wdc_pkg::OFS_CLK_SEL, 16'hffff, 16'h0000);  // select default
    rm(wdc_pkg::OFS_MON_CTL, 16'hffff, 16'h0003);  // monitor default
    rm(wdc_pkg::OFS_FLAGS, 16'h0017, 16'h0000);  // flags clear
    rm(8'h40, 16'hffff, 16'h0000);  // unmapped reads zero
    osc(80);
    wr(wdc_pkg::OFS_WDOG_SVC, 16'h0033);
    cyc(3);
    chk(16'(n_wdr), 16'h0000);  // idle watchdog
    $display("test defaults done");
    for (int r = 1; r <= 3; r++) begin
      b = n_wdr;
      wr(wdc_pkg::OFS_WDOG_CTL, 16'(r));
      osc((1 << (WD + 2 * r)) - 2);
      cyc(3);
      chk(16'(n_wdr - b), 16'h0000);  // period length
      osc(4);
      cyc(3);
      chk(16'(n_wdr - b), 16'h0001);  // expiry reset
    end
    b = n_wdr;
    wr(wdc_pkg::OFS_WDOG_CTL, 16'h0001);
    wr(wdc_pkg::OFS_WDOG_SVC, 16'h0033);
    cyc(3);
    chk(16'(n_wdr - b), 16'h0001);  // bad key
    wr(wdc_pkg::OFS_WDOG_CTL, 16'h0001);
    osc(40);
    wr(wdc_pkg::OFS_WDOG_SVC, wdc_pkg::SVC_KEY1);
    wr(wdc_pkg::OFS_WDOG_SVC, wdc_pkg::SVC_KEY2);
    osc(40);
    cyc(3);
    chk(16'(n_wdr - b), 16'h0001);  // key pair restarts
    // Window mode: early service resets, late service is accepted
    wr(wdc_pkg::OFS_WDOG_CTL, 16'h0041);
    osc(10);
    wr(wdc_pkg::OFS_WDOG_SVC, wdc_pkg::SVC_KEY1);
    cyc(3);
    chk(16'(n_wdr - b), 16'h0002);  // early write
    wr(wdc_pkg::OFS_WDOG_CTL, 16'h0041);
    osc(50);
    wr(wdc_pkg::OFS_WDOG_SVC, wdc_pkg::SVC_KEY1);
    wr(wdc_pkg::OFS_WDOG_SVC, wdc_pkg::SVC_KEY2);
    osc(50);
    cyc(3);
    chk(16'(n_wdr - b), 16'h0002);  // late service
    wr(wdc_pkg::OFS_WDOG_CTL, 16'h0001);
    pseudo_stop <= 1'h1;
    osc(70);
    cyc(3);
    chk(16'(n_wdr - b), 16'h0002);  // frozen without enable
    wr(wdc_pkg::OFS_CLK_SEL, 16'h0040);
    osc(66);
    cyc(3);
    chk(16'(n_wdr - b), 16'h0003);  // counts with enable
    pseudo_stop <= 1'h0;
    wr(wdc_pkg::OFS_WDOG_CTL, 16'h0000);
    wr(wdc_pkg::OFS_CLK_SEL, 16'h0000);
    $display("test watchdog done");
    wr(wdc_pkg::OFS_MON_CTL, 16'h000b);
    wr(wdc_pkg::OFS_PER_RATE, 16'h0001);
    osc(15);
    rm(wdc_pkg::OFS_FLAGS, 16'h0001, 16'h0000);  // not yet
    osc(1);
    cyc(2);
    chk({15'h0, periodic_irq}, 16'h0001);  // interrupt raised
    rm(wdc_pkg::OFS_FLAGS, 16'h0001, 16'h0001);  // flag set
    wr(wdc_pkg::OFS_FLAGS, 16'h0001);
    osc(15);
    rm(wdc_pkg::OFS_FLAGS, 16'h0001, 16'h0000);  // cleared
    osc(1);
    rm(wdc_pkg::OFS_FLAGS, 16'h0001, 16'h0001);  // immediate restart
    wr(wdc_pkg::OFS_FLAGS, 16'h0001);
    osc(10);
    wr(wdc_pkg::OFS_PER_RATE, 16'h0001);
    osc(10);
    rm(wdc_pkg::OFS_FLAGS, 16'h0001, 16'h0000);  // rate write restarts
    osc(6);
    rm(wdc_pkg::OFS_FLAGS, 16'h0001, 16'h0001);  // full interval
    wr(wdc_pkg::OFS_FLAGS, 16'h0001);
    pseudo_stop <= 1'h1;
    wr(wdc_pkg::OFS_PER_RATE, 16'h0001);
    osc(20);
    rm(wdc_pkg::OFS_FLAGS, 16'h0001, 16'h0000);  // frozen in pseudo-stop
    chk({15'h0, gate.voltage_regulator_en}, 16'h0000);  // regulator off without check
    wr(wdc_pkg::OFS_CLK_SEL, 16'h0020);
    osc(16);
    rm(wdc_pkg::OFS_FLAGS, 16'h0001, 16'h0001);  // runs in pseudo-stop
    wr(wdc_pkg::OFS_CLK_SEL, 16'h0000);
    pseudo_stop <= 1'h0;
    wr(wdc_pkg::OFS_PER_RATE, 16'h0000);
    wr(wdc_pkg::OFS_FLAGS, 16'h0001);
    osc(40);
    cyc(2);
    chk({15'h0, periodic_irq}, 16'h0000);  // zero rate stops
    $display("test periodic done");
    wr(wdc_pkg::OFS_MON_CTL, 16'h0003);
    wr(wdc_pkg::OFS_CLK_SEL, 16'h0080);
    cyc(1);
    chk({15'h0, pll_clock_select}, 16'h0001);  // select set first
    pls(0);
    cyc(2);
    chk({15'h0, self_clock_mode}, 16'h0001);  // self-clock entered
    chk({15'h0, pll_clock_select}, 16'h0000);  // select cleared
    rm(wdc_pkg::OFS_FLAGS, 16'h0006, 16'h0006);  // flag and mode
    osc(5);
    @(posedge ref_clk);
    vco_tick <= 1'h1;
    repeat (21) @(posedge ref_clk);
    vco_tick <= 1'h0;
    osc(5);
    cyc(3);
    chk({15'h0, self_clock_mode}, 16'h0001);  // window restarts count
    osc(3);
    cyc(3);
    chk({15'h0, self_clock_mode}, 16'h0000);  // leaves on good clock
    wr(wdc_pkg::OFS_FLAGS, 16'h0002);
    b = n_cmr;
    wr(wdc_pkg::OFS_MON_CTL, 16'h0001);
    pls(0);
    cyc(3);
    chk(16'(n_cmr - b), 16'h0001);  // monitor reset
    chk({15'h0, self_clock_mode}, 16'h0000);  // no self-clock
    rm(wdc_pkg::OFS_MON_CTL, 16'h0002, 16'h0002);  // enable forced
    $display("test selfclock done");
    // Timer wait-stop bits freeze both timers only while waiting
    b = n_wdr;
    wr(wdc_pkg::OFS_CLK_SEL, 16'h0003);
    wr(wdc_pkg::OFS_WDOG_CTL, 16'h0001);
    wr(wdc_pkg::OFS_PER_RATE, 16'h0001);
    pls(1);
    cyc(6);
    osc(70);
    cyc(2);
    chk(16'(n_wdr - b), 16'h0000);  // watchdog held in wait
    rm(wdc_pkg::OFS_FLAGS, 16'h0011, 16'h0010);  // periodic held in wait
    pls(2);
    osc(64);
    cyc(3);
    chk(16'(n_wdr - b), 16'h0001);  // watchdog runs after wake
    rm(wdc_pkg::OFS_FLAGS, 16'h0001, 16'h0001);  // periodic runs after wake
    chk({15'h0, periodic_irq}, 16'h0000);  // masked without enable
    wr(wdc_pkg::OFS_WDOG_CTL, 16'h0000);
    wr(wdc_pkg::OFS_PER_RATE, 16'h0000);
    wr(wdc_pkg::OFS_FLAGS, 16'h0001);
    wr(wdc_pkg::OFS_CLK_SEL, 16'h019c);
    t_pll = 0;
    t_core = 0;
    t_sys = 0;
    pls(1);
    cyc(6);
    chk({15'h0, wait_active}, 16'h0001);  // wait reached
    chk({11'h0, gate}, 16'h0009);  // gating bits
    chk({15'h0, pll_clock_select}, 16'h0000);  // select dropped
    chk(16'(t_core > t_pll && t_sys > t_core), 16'h0001);  // shutdown order
    pls(2);
    cyc(3);
    chk({15'h0, wait_active}, 16'h0000);  // wake at once
    chk({13'h0, gate.core_en, gate.sys_en, gate.osc_reduce}, 16'h0006);  // clocks back
    chk({15'h0, pll_clock_select}, 16'h0000);  // select stays clear
    wr(wdc_pkg::OFS_CLK_SEL, 16'h0104);
    wr(wdc_pkg::OFS_MON_CTL, 16'h0003);
    pls(1);
    cyc(6);
    chk({15'h0, gate.pll_en}, 16'h0000);  // pll stopped
    pls(0);
    cyc(3);
    chk({15'h0, wait_active}, 16'h0001);  // no wake unmasked
    chk({15'h0, self_clock_mode}, 16'h0001);  // mode entered
    chk({14'h0, gate.pll_en, gate.voltage_regulator_en}, 16'h0003);  // pll and regulator on
    wr(wdc_pkg::OFS_MON_CTL, 16'h0007);
    cyc(3);
    chk({15'h0, self_clock_irq}, 16'h0001);  // interrupt raised
    chk({15'h0, wait_active}, 16'h0000);  // wakes
    osc(8);
    cyc(3);
    chk({15'h0, self_clock_mode}, 16'h0000);  // check completes
    wr(wdc_pkg::OFS_FLAGS, 16'h0002);
    wr(wdc_pkg::OFS_CLK_SEL, 16'h011c);
    pls(1);
    cyc(6);
    // Asynchronous: visible before the next edge
    @(posedge ref_clk);
    rst_n <= 1'h0;
    #2;
    chk({11'h0, gate}, 16'h001e);  // async restore
    chk({15'h0, wait_active}, 16'h0000);  // wait left
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'h1;
    rm(wdc_pkg::OFS_CLK_SEL, 16'hffff, 16'h0000);  // config default
    rm(wdc_pkg::OFS_MON_CTL, 16'hffff, 16'h0003);  // monitor default
    $display("test wait done");
    close_out();
  end
endmodule // wdc_tb_top
